// ---- design/sar_ctrl_map.vh ----
`ifndef SAR_CTRL_MAP_VH
`define SAR_CTRL_MAP_VH

// Register byte addresses
`define ADDR_CONTROL 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_CONVLEN 4'h8
// Control register fields
`define CTRL_SLEEP_BIT 0
`define CTRL_REGSEL_BIT 1
`define CTRL_RESET 2'h0
// Status register fields
`define STAT_BUSY_BIT 0
`define STAT_SLEEP_BIT 1
`define STAT_ANALOG_BIT 2
`define STAT_REFEN_BIT 3
`define STAT_BUFEN_BIT 4
`define STAT_TEMPEN_BIT 5
// Conversion time in ns and its cycle count at the 20 ns clock
`define CONV_TIME_NS 700
`define CLK_PERIOD_NS 20
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ---- design/edge_sync.v ----
`timescale 1ns/1ps
`default_nettype none
module edge_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
)(
    input wire ref_clk,
    input wire reset,
    input wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut,
    output wire [WIDTH-1:0] fallPulse
);
    reg [WIDTH-1:0] stage1_reg;
    reg [WIDTH-1:0] stage2_reg;
    reg [WIDTH-1:0] prev_reg;

    // Resets to each pin's idle level, so reset shows neither a false edge nor a false level
    always @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            stage1_reg <= INIT;
            stage2_reg <= INIT;
            prev_reg <= INIT;
        end
        else
        begin
            stage1_reg <= asyncIn;
            stage2_reg <= stage1_reg;
            prev_reg <= stage2_reg;
        end
    end

    assign syncOut = stage2_reg;
    assign fallPulse = prev_reg & ~stage2_reg;
endmodule
`default_nettype wire

// ---- design/sar_conversion_and_power_control.v ----
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "sar_ctrl_map.vh"
module sar_conversion_and_power_control #(
    parameter CONV_LEN = `CONV_CYCLES
)(
    input wire ref_clk,
    input wire reset,
    input wire conversion_start_n,
    input wire sleep_request,
    input wire ref_shutdown,
    input wire refbuf_shutdown,
    input wire fast_mode_sel,
    input wire pulse_power_mode,
    input wire [3:0] avsAddress,
    input wire avsRead,
    input wire avsWrite,
    input wire [31:0] avsWriteData,
    input wire [3:0] avsByteEnable,
    output reg [31:0] avsReadData,
    output wire avsWaitRequest,
    output reg busy,
    output reg convStrobe,
    output reg analogPowerEn,
    output reg coreSleep,
    output reg bandgapEn,
    output reg refBufferEn,
    output reg tempSenseEn
);
    localparam ST_IDLE = 2'd0;
    localparam ST_CONV = 2'd1;
    localparam ST_ACQ = 2'd2;
    localparam ST_SLEEP = 2'd3;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    wire [5:0] pinSync;
    wire [5:0] pinFall;

    // Start pin idles high; the level pins start low so no sleep or reference
    // shutdown is seen before the pins have really been sampled
    edge_sync #(
        .WIDTH(6),
        .INIT(6'h01)
    ) u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .asyncIn({pulse_power_mode, fast_mode_sel, refbuf_shutdown, ref_shutdown,
            sleep_request, conversion_start_n}),
        .syncOut(pinSync),
        .fallPulse(pinFall)
    );

    // Start edge depends on nothing but the pin itself
    wire startEdge = pinFall[0];
    wire sleepPin = pinSync[1];
    wire refOff = pinSync[2];
    wire bufOff = pinSync[3];
    wire lowPowerMode = ~pinSync[4] & pinSync[5];

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    reg [1:0] ctrl_reg;
    reg [15:0] convLen_reg;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [15:0] count_reg;
    reg [15:0] count_next;
    reg readValid_reg;

    // Writes finish at once; a read waits one cycle so its data already stands
    // in the output flops at the edge where waitrequest is seen low
    assign avsWaitRequest = avsRead & ~readValid_reg;

    always @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            readValid_reg <= 1'b0;
        else
            readValid_reg <= avsRead & ~readValid_reg;
    end

    function isAddr;
        input [3:0] a;
        input [3:0] b;
        begin
            isAddr = (a == b);
        end
    endfunction

    always @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            ctrl_reg <= `CTRL_RESET;
            convLen_reg <= 16'h0000;
        end
        else if (avsWrite)
        begin
            if (isAddr(avsAddress, `ADDR_CONTROL) && avsByteEnable[0])
                ctrl_reg <= avsWriteData[1:0];
            if (isAddr(avsAddress, `ADDR_CONVLEN) && avsByteEnable[0])
                convLen_reg[7:0] <= avsWriteData[7:0];
            if (isAddr(avsAddress, `ADDR_CONVLEN) && avsByteEnable[1])
                convLen_reg[15:8] <= avsWriteData[15:8];
        end
    end

    always @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            avsReadData <= 32'h00000000;
        else if (avsRead && !readValid_reg)
        begin
            if (isAddr(avsAddress, `ADDR_CONTROL))
                avsReadData <= {30'h00000000, ctrl_reg};
            else if (isAddr(avsAddress, `ADDR_STATUS))
                avsReadData <= {26'h0000000, tempSenseEn, refBufferEn, bandgapEn,
                    analogPowerEn, coreSleep, busy};
            else if (isAddr(avsAddress, `ADDR_CONVLEN))
                avsReadData <= {16'h0000, convLen_reg};
            else
                avsReadData <= 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // Conversion and power sequencer
    // ------------------------------------------------------------
    // Register bit takes over the sleep source; pin then ignored
    wire sleepWanted = ctrl_reg[`CTRL_REGSEL_BIT] ? ctrl_reg[`CTRL_SLEEP_BIT]
        : sleepPin;
    // Zero in the length register selects the default conversion length
    wire [15:0] convLast = (convLen_reg == 16'h0000) ? CONV_LEN[15:0] - 16'h0001
        : convLen_reg - 16'h0001;

    always @*
    begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            ST_IDLE, ST_ACQ:
            begin
                if (sleepWanted)
                    state_next = ST_SLEEP;
                else if (startEdge)
                begin
                    state_next = ST_CONV;
                    count_next = 16'h0000;
                end
            end
            ST_CONV:
            begin
                // Start edges and sleep are ignored until the count runs out
                if (count_reg >= convLast)
                    state_next = sleepWanted ? ST_SLEEP : ST_ACQ;
                else
                    count_next = count_reg + 16'h0001;
            end
            ST_SLEEP:
            begin
                if (!sleepWanted)
                    state_next = ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            state_reg <= ST_IDLE;
            count_reg <= 16'h0000;
            busy <= 1'b0;
            convStrobe <= 1'b0;
            analogPowerEn <= 1'b1;
            coreSleep <= 1'b0;
            bandgapEn <= 1'b1;
            refBufferEn <= 1'b1;
            tempSenseEn <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            count_reg <= count_next;
            busy <= (state_next == ST_CONV);
            convStrobe <= (state_reg != ST_CONV) && (state_next == ST_CONV);
            coreSleep <= (state_next == ST_SLEEP);
            // Only analog power drops; the bus logic keeps running in every state
            analogPowerEn <= (state_next == ST_CONV) ||
                ((state_next != ST_SLEEP) && !lowPowerMode);
            bandgapEn <= ~refOff;
            refBufferEn <= ~bufOff;
            tempSenseEn <= ~refOff & ~bufOff;
        end
    end
endmodule
`default_nettype wire

// ---- bench/sar_ctrl_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module sar_ctrl_properties #(
    parameter CONV_LEN = 35
)(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic conversion_start_n,
    input wire logic sleep_request,
    input wire logic ref_shutdown,
    input wire logic refbuf_shutdown,
    input wire logic busy,
    input wire logic convStrobe,
    input wire logic analogPowerEn,
    input wire logic coreSleep,
    input wire logic bandgapEn,
    input wire logic refBufferEn,
    input wire logic tempSenseEn
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    logic [2:0] upCount;
    logic [7:0] busyCount;
    // Pins pass synchronisers, so the start and reference checks judge nothing in the first edges after reset
    always @(posedge ref_clk or posedge reset)
    begin
        upCount <= reset ? 3'h0 : upCount + {2'h0, upCount != 3'h7};
        busyCount <= (reset || !busy) ? 8'h00 : busyCount + 8'h01;
    end
    sequence startFall;
        upCount == 3'h7 && $fell(conversion_start_n) && !busy && !coreSleep && !sleep_request;
    endsequence
    sequence held(logic [1:0] sel);
        (upCount == 3'h7 && {ref_shutdown, refbuf_shutdown} == sel) [*5];
    endsequence
    chk_start_latency: assert property (startFall |-> ##[1:5] convStrobe)
        else $error("start edge not taken");
    chk_strobe_busy: assert property (convStrobe |-> busy ##1 !convStrobe)
        else $error("strobe without busy");
    chk_no_restart: assert property (busy && $past(busy) |-> !convStrobe)
        else $error("conversion restarted");
    chk_busy_length: assert property ($fell(busy) |-> busyCount == CONV_LEN)
        else $error("busy length wrong");
    chk_sleep_defer: assert property (busy |-> !coreSleep)
        else $error("slept mid conversion");
    chk_busy_analog: assert property (busy |-> analogPowerEn)
        else $error("analog off in conversion");
    chk_ref_internal: assert property (held(2'h0) |->
        bandgapEn && refBufferEn && tempSenseEn)
        else $error("internal reference off");
    chk_ref_direct: assert property (held(2'h3) |-> !bandgapEn && !refBufferEn)
        else $error("reference still powered");
endmodule
bind sar_conversion_and_power_control sar_ctrl_properties #(.CONV_LEN(CONV_LEN)) u_props (
    .ref_clk(ref_clk),
    .reset(reset),
    .conversion_start_n(conversion_start_n),
    .sleep_request(sleep_request),
    .ref_shutdown(ref_shutdown),
    .refbuf_shutdown(refbuf_shutdown),
    .busy(busy),
    .convStrobe(convStrobe),
    .analogPowerEn(analogPowerEn),
    .coreSleep(coreSleep),
    .bandgapEn(bandgapEn),
    .refBufferEn(refBufferEn),
    .tempSenseEn(tempSenseEn)
);
`default_nettype wire

// ---- bench/host_pins.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_pins (
    output var logic conversion_start_n,
    output var logic sleep_request,
    output var logic ref_shutdown,
    output var logic refbuf_shutdown,
    output var logic fast_mode_sel,
    output var logic pulse_power_mode
);
    initial drive(6'h20);
    // Called just after a clock edge; the levels then stand until the next call
    task automatic drive(input logic [5:0] v);
        {conversion_start_n, sleep_request} <= v[5:4];
        {ref_shutdown, refbuf_shutdown} <= v[3:2];
        {fast_mode_sel, pulse_power_mode} <= v[1:0];
    endtask
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic ref_clk, reset, avsRead, avsWrite, avsWaitRequest;
    logic [3:0] avsAddress, pins;
    logic [3:0] avsByteEnable = 4'hf;
    logic [31:0] avsWriteData, avsReadData, n;
    logic busy, convStrobe, analogPowerEn, coreSleep, bandgapEn, refBufferEn, tempSenseEn;
    wire logic conversion_start_n, sleep_request, ref_shutdown, refbuf_shutdown;
    wire logic fast_mode_sel, pulse_power_mode;
    logic [1:0] refSel [3] = '{2'h0, 2'h2, 2'h3};
    logic [31:0] refExp [3] = '{32'h38, 32'h10, 32'h0};
    int n_mismatch = 0, checks = 0;
    sar_conversion_and_power_control #(.CONV_LEN(8)) u_sar_conversion_and_power_control (
        .ref_clk(ref_clk),
        .reset(reset),
        .conversion_start_n(conversion_start_n),
        .sleep_request(sleep_request),
        .ref_shutdown(ref_shutdown),
        .refbuf_shutdown(refbuf_shutdown),
        .fast_mode_sel(fast_mode_sel),
        .pulse_power_mode(pulse_power_mode),
        .avsAddress(avsAddress),
        .avsRead(avsRead),
        .avsWrite(avsWrite),
        .avsWriteData(avsWriteData),
        .avsByteEnable(avsByteEnable),
        .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest),
        .busy(busy),
        .convStrobe(convStrobe),
        .analogPowerEn(analogPowerEn),
        .coreSleep(coreSleep),
        .bandgapEn(bandgapEn),
        .refBufferEn(refBufferEn),
        .tempSenseEn(tempSenseEn)
    );
    host_pins u_host_pins (
        .conversion_start_n(conversion_start_n),
        .sleep_request(sleep_request),
        .ref_shutdown(ref_shutdown),
        .refbuf_shutdown(refbuf_shutdown),
        .fast_mode_sel(fast_mode_sel),
        .pulse_power_mode(pulse_power_mode)
    );
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        n_mismatch++;
        conclude();
    end
    task automatic conclude();
        if (n_mismatch == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    // For a read, d is the expected value; read data is registered one edge before the accepting edge
    task automatic access(input logic wr, input logic [3:0] a, input logic [31:0] d,
        input logic [31:0] m);
        {avsWrite, avsRead, avsAddress, avsWriteData} <= {wr, !wr, a, d};
        do @(posedge ref_clk); while (avsWaitRequest !== 1'b0);
        if (!wr)
            compare(avsReadData & m, d & m);
        {avsWrite, avsRead} <= 2'h0;
        @(posedge ref_clk);
    endtask
    // A second start edge falls inside the conversion and must not stretch it
    task automatic convert(input logic sl, input logic [31:0] len);
        n = 0;
        for (int i = 0; i < 30; i++)
        begin
            u_host_pins.drive({i > 2 && i != 5 && i != 6, sl && i > 5, pins});
            @(posedge ref_clk);
            n += busy === 1'b1;
        end
        compare(n, len);
    endtask
    initial
    begin
        reset = 1'b1;
        {avsRead, avsWrite, avsAddress, avsWriteData, pins} = '0;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (8) @(posedge ref_clk);
        access(0, 4'h4, 32'h3c, 32'h3f);
        access(0, 4'hc, 32'h0, 32'hffffffff);
        convert(0, 8);
        convert(1, 8);
        access(0, 4'h4, 32'h2, 32'h3);
        access(1, 4'h0, 32'h3, 32'h0);
        access(0, 4'h0, 32'h3, 32'h3);
        convert(0, 0);
        access(0, 4'h4, 32'h2, 32'h3);
        access(1, 4'h0, 32'h2, 32'h0);
        u_host_pins.drive({2'h3, pins});
        repeat (5) @(posedge ref_clk);
        access(0, 4'h4, 32'h0, 32'h3);
        u_host_pins.drive({2'h2, pins});
        access(1, 4'h0, 32'h0, 32'h0);
        access(1, 4'h8, 32'h1234, 32'h0);
        access(0, 4'h8, 32'h1234, 32'hffffffff);
        access(1, 4'h8, 32'h0, 32'h0);
        repeat (5) @(posedge ref_clk);
        pins = 4'h1;
        convert(0, 8);
        access(0, 4'h4, 32'h0, 32'h5);
        for (int k = 0; k < 3; k++)
        begin
            pins = {refSel[k], 2'h0};
            u_host_pins.drive({2'h2, pins});
            repeat (6) @(posedge ref_clk);
            access(0, 4'h4, refExp[k], 32'h38);
        end
        conclude();
    end
endmodule
`default_nettype wire
